// ==== rtl/odc_pkg.sv ====
package odc_pkg;
   // Bus mode select
   localparam logic [1:0] MODE_I80 = 2'h0;
   localparam logic [1:0] MODE_M68 = 2'h1;
   localparam logic [1:0] MODE_SER = 2'h2;
   // Command codes and masks
   localparam logic [7:0] CMD_COL_LO = 8'h00;
   localparam logic [7:0] CMD_COL_HI = 8'h10;
   localparam logic [7:0] CMD_PUMP_V = 8'h30;
   localparam logic [7:0] CMD_START = 8'h40;
   localparam logic [7:0] CMD_CONTRAST = 8'h81;
   localparam logic [7:0] CMD_PUMP_OFF = 8'h8A;
   localparam logic [7:0] CMD_PUMP_ON = 8'h8B;
   localparam logic [7:0] CMD_REMAP_N = 8'hA0;
   localparam logic [7:0] CMD_REMAP_R = 8'hA1;
   localparam logic [7:0] CMD_ALL_OFF = 8'hA4;
   localparam logic [7:0] CMD_ALL_ON = 8'hA5;
   localparam logic [7:0] CMD_NORMAL = 8'hA6;
   localparam logic [7:0] CMD_REVERSE = 8'hA7;
   // Reset values and last column
   localparam logic [7:0] RST_CONTRAST = 8'h80;
   localparam logic [1:0] RST_PUMP_V = 2'h2;
   localparam logic [5:0] RST_START = 6'h00;
   localparam logic [7:0] RST_COLUMN = 8'h00;
   localparam logic RST_PUMP_ON = 1'b1;
   localparam logic [7:0] COL_LAST = 8'h83;
   // Host strobe and serial clock timing in cycles of i_clock: setup HOST_SETUP_CYC, pulse HOST_PULSE_CYC+4, serial half period SER_HALF_CYC+2
   localparam int HOST_SETUP_CYC = 2;
   localparam int HOST_PULSE_CYC = 2;
   localparam int SER_HALF_CYC = 2;
endpackage

// ==== rtl/odc_bus_if.sv ====
`timescale 1ns/100ps
interface odc_bus_if;
   logic [1:0] mode;
   logic dc_sel;
   logic rd_n_e;
   logic wr_n_rw;
   logic [7:0] data_host;
   logic [7:0] data_dev;
   logic data_dev_oe;
   logic ser_clk;
   logic ser_cs_n;
   logic [7:0] data;
   assign data = data_dev_oe ? data_dev : data_host;
   modport host (
      output mode, dc_sel, rd_n_e, wr_n_rw, data_host, ser_clk, ser_cs_n,
      input data
   );
   modport device (
      input mode, dc_sel, rd_n_e, wr_n_rw, data_host, ser_clk, ser_cs_n,
      output data_dev, data_dev_oe
   );
endinterface

// ==== rtl/odc_device.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// [R1] Oscillator runs only while select input high
// [R2] Charge pump toggled by command, 8Bh on
// [R3] Clear forces display off, outputs high-impedance
// [R4] Reset clears shifter, normal mapping, column zero
// [R5] Reset: start line 0, contrast 80h
// [R6] 8080 mode: low read/write strobes with select
// [R7] 6800 mode: direction line, high enable strobe
// [R8] Commands complete internally, no busy wait
// [R9] Serial bytes shift in MSB first
// [R10] 00h-0Fh low nibble, 10h-1Fh high nibble
// [R11] Column increments per RAM access, stops 131
// [R12] 30h-33h set pump voltage code
// [R13] 40h-7Fh set six-bit start line
// [R14] After 81h next byte is contrast
// [R15] Contrast eight bits, 256 levels
// [R16] Host writes 80h when contrast unused
// [R17] A0h normal, A1h reversed segment map
// [R18] A5h forces all pixels, overrides reverse
// [R19] A6h normal, A7h reverse display
// [R20] Host issues only defined commands
// [R21] Select high: RAM data; low: command
module odc_device (
   input wire logic i_clock,
   input wire logic i_rstn,
   odc_bus_if.device bus,
   input wire logic i_internal_osc_select,
   input wire logic i_outside_tick_pin,
   input wire logic i_chip_clear_input_n,
   input wire logic [7:0] i_ram_rdata,
   output logic o_osc_run,
   output logic o_disp_tick,
   output logic o_pump_on,
   output logic [1:0] o_pump_volt,
   output logic [7:0] o_contrast,
   output logic [5:0] o_start_line,
   output logic o_seg_reverse,
   output logic o_all_on,
   output logic o_invert,
   output logic o_display_on,
   output logic o_driver_hiz,
   output logic [7:0] o_column,
   output logic o_ram_we,
   output logic [7:0] o_ram_wdata
);
   logic [1:0] mode_s1, mode_s2;
   logic dc_s1, dc_s2, rd_s1, rd_s2, wr_s1, wr_s2;
   logic sck_s1, sck_s2, cs_s1, cs_s2, cls_s1, cls_s2, cl_s1, cl_s2, clr_s1, clr_s2;
   logic [7:0] d_s1, d_s2;
   logic rd_d, wr_d, sck_d, cl_d;
   logic [1:0] mode_d;
   logic rd_open;
   logic [7:0] shift_reg;
   logic [2:0] bit_cnt_reg;
   logic contrast_pend_reg;
   logic osc_div_reg;
   logic wr_ev, rd_ev, ser_ev;
   logic [7:0] byte_in;
   logic ser_done;
   logic [7:0] data_dev_reg;
   logic data_oe_reg;

   function automatic logic col_step(input logic [7:0] col);
      return col != package_col_last();
   endfunction
   function automatic logic [7:0] package_col_last();
      return odc_pkg::COL_LAST;
   endfunction

   // Two-stage synchronisers for all pins except i_ram_rdata
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         {mode_s1, mode_s2} <= 4'h0;
         {dc_s1, dc_s2, rd_s1, rd_s2, wr_s1, wr_s2} <= 6'h3F;
         {sck_s1, sck_s2, cs_s1, cs_s2} <= 4'hF;
         {cls_s1, cls_s2, cl_s1, cl_s2} <= 4'h0;
         {clr_s1, clr_s2} <= 2'h3;
         {d_s1, d_s2} <= 16'h0000;
      end else begin
         mode_s1 <= bus.mode;
         mode_s2 <= mode_s1;
         dc_s1 <= bus.dc_sel;
         dc_s2 <= dc_s1;
         rd_s1 <= bus.rd_n_e;
         rd_s2 <= rd_s1;
         wr_s1 <= bus.wr_n_rw;
         wr_s2 <= wr_s1;
         sck_s1 <= bus.ser_clk;
         sck_s2 <= sck_s1;
         cs_s1 <= bus.ser_cs_n;
         cs_s2 <= cs_s1;
         cls_s1 <= i_internal_osc_select;
         cls_s2 <= cls_s1;
         cl_s1 <= i_outside_tick_pin;
         cl_s2 <= cl_s1;
         clr_s1 <= i_chip_clear_input_n;
         clr_s2 <= clr_s1;
         d_s1 <= bus.data_host;
         d_s2 <= d_s1;
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         {rd_d, wr_d, sck_d, cl_d} <= 4'hF;
         mode_d <= 2'h0;
      end else begin
         mode_d <= mode_s2;
         rd_d <= rd_s2;
         wr_d <= wr_s2;
         sck_d <= sck_s2;
         cl_d <= cl_s2;
      end
   end

   always_comb begin
      wr_ev = 1'b0;
      rd_ev = 1'b0;
      rd_open = 1'b0;
      // Strobe edges seen while the mode settles are ignored
      case (mode_s2 == mode_d ? mode_s2 : 2'h3)
         // [R6] 8080 strobes
         odc_pkg::MODE_I80: begin
            wr_ev = wr_s2 && !wr_d;
            rd_ev = rd_s2 && !rd_d;
            rd_open = !rd_s2 && rd_d;
         end
         // [R7] 6800 enable edge
         odc_pkg::MODE_M68: begin
            wr_ev = !rd_s2 && rd_d && !wr_s2;
            rd_ev = !rd_s2 && rd_d && wr_s2;
            rd_open = rd_s2 && !rd_d && wr_s2;
         end
         default: begin
            wr_ev = 1'b0;
            rd_ev = 1'b0;
            rd_open = 1'b0;
         end
      endcase
   end

   assign ser_ev = (mode_s2 == odc_pkg::MODE_SER) && !cs_s2 && sck_s2 && !sck_d;
   assign ser_done = ser_ev && (bit_cnt_reg == 3'h7);
   assign byte_in = ser_done ? {shift_reg[6:0], d_s2[0]} : d_s2;

   // [R9] MSB first shift
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         shift_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
      end else if (cs_s2 || mode_s2 != odc_pkg::MODE_SER) begin
         bit_cnt_reg <= 3'h0;
      end else if (ser_ev) begin
         shift_reg <= {shift_reg[6:0], d_s2[0]};
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   logic take;
   assign take = wr_ev || ser_done;

   // [R21] Data or command routing
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_ram_we <= 1'b0;
         o_ram_wdata <= 8'h00;
      end else begin
         o_ram_we <= take && dc_s2;
         if (take && dc_s2)
            o_ram_wdata <= byte_in;
      end
   end

   // [R8] Single-cycle command decode
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         // [R5] Reset defaults
         o_contrast <= odc_pkg::RST_CONTRAST;
         o_start_line <= odc_pkg::RST_START;
         o_pump_volt <= odc_pkg::RST_PUMP_V;
         o_pump_on <= odc_pkg::RST_PUMP_ON;
         // [R4] Normal mapping
         o_seg_reverse <= 1'b0;
         o_all_on <= 1'b0;
         o_invert <= 1'b0;
         contrast_pend_reg <= 1'b0;
      end else if (take && !dc_s2) begin
         if (contrast_pend_reg) begin
            // [R14] Contrast data byte
            // [R15] Full eight bits
            o_contrast <= byte_in;
            contrast_pend_reg <= 1'b0;
         end else if (byte_in == odc_pkg::CMD_CONTRAST) begin
            contrast_pend_reg <= 1'b1;
         end else if (byte_in[7:2] == odc_pkg::CMD_PUMP_V[7:2]) begin
            // [R12] Pump voltage code
            o_pump_volt <= byte_in[1:0];
         end else if (byte_in[7:6] == odc_pkg::CMD_START[7:6]) begin
            // [R13] Start line
            o_start_line <= byte_in[5:0];
         end else if (byte_in == odc_pkg::CMD_PUMP_ON) begin
            // [R2] Pump on
            o_pump_on <= 1'b1;
         end else if (byte_in == odc_pkg::CMD_PUMP_OFF) begin
            o_pump_on <= 1'b0;
         end else if (byte_in == odc_pkg::CMD_REMAP_N || byte_in == odc_pkg::CMD_REMAP_R) begin
            // [R17] Segment map
            o_seg_reverse <= byte_in[0];
         end else if (byte_in == odc_pkg::CMD_ALL_OFF || byte_in == odc_pkg::CMD_ALL_ON) begin
            // [R18] Entire display
            o_all_on <= byte_in[0];
         end else if (byte_in == odc_pkg::CMD_NORMAL || byte_in == odc_pkg::CMD_REVERSE) begin
            // [R19] Inversion flag
            o_invert <= byte_in[0];
         end
      end
   end

   // [R10] Column nibbles
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_column <= odc_pkg::RST_COLUMN;
      end else if (take && !dc_s2 && !contrast_pend_reg && byte_in[7:4] == 4'h0) begin
         o_column[3:0] <= byte_in[3:0];
      end else if (take && !dc_s2 && !contrast_pend_reg && byte_in[7:4] == 4'h1) begin
         o_column[7:4] <= byte_in[3:0];
      // [R11] Column increment
      end else if ((take && dc_s2) || (rd_ev && dc_s2)) begin
         if (col_step(o_column))
            o_column <= o_column + 8'h01;
      end
   end

   // Read data drive onto the bus
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         data_dev_reg <= 8'h00;
         data_oe_reg <= 1'b0;
      end else begin
         // Read data must stand while the read strobe is active
         if (rd_open)
            data_dev_reg <= dc_s2 ? i_ram_rdata : 8'h00;
         data_oe_reg <= (mode_s2 == odc_pkg::MODE_I80) ? !rd_s2 :
            (mode_s2 == odc_pkg::MODE_M68) ? (rd_s2 && wr_s2) : 1'b0;
      end
   end
   assign bus.data_dev = data_dev_reg;
   assign bus.data_dev_oe = data_oe_reg;

   // [R1] Clock source selection
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_osc_run <= 1'b0;
         osc_div_reg <= 1'b0;
         o_disp_tick <= 1'b0;
      end else begin
         o_osc_run <= cls_s2;
         osc_div_reg <= cls_s2 ? !osc_div_reg : 1'b0;
         o_disp_tick <= cls_s2 ? osc_div_reg : (cl_s2 && !cl_d);
      end
   end

   // [R3] Clear input forces off
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         o_display_on <= 1'b0;
         o_driver_hiz <= 1'b1;
      end else begin
         o_display_on <= 1'b0;
         o_driver_hiz <= !clr_s2 || !o_display_on;
      end
   end
endmodule

// ==== rtl/odc_host.sv ====
`timescale 1ns/100ps
module odc_host (
   input wire logic i_clock,
   input wire logic i_rstn,
   odc_bus_if.host bus,
   input wire logic [1:0] i_mode,
   input wire logic i_start,
   input wire logic i_is_read,
   input wire logic i_dc,
   input wire logic [7:0] i_wdata,
   output logic o_busy,
   output logic o_done,
   output logic [7:0] o_rdata
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_PULSE = 4'b0100,
      ST_SER = 4'b1000
   } odc_state_e;
   odc_state_e state_reg;
   logic [3:0] cnt_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   logic rd_reg;
   logic [1:0] mode_reg;
   logic dc_reg, rdn_reg, wrn_reg, sck_reg, csn_reg;
   logic [7:0] d_s1, d_s2;

   assign bus.mode = mode_reg;
   assign bus.dc_sel = dc_reg;
   assign bus.rd_n_e = rdn_reg;
   assign bus.wr_n_rw = wrn_reg;
   assign bus.data_host = sh_reg;
   assign bus.ser_clk = sck_reg;
   assign bus.ser_cs_n = csn_reg;

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         d_s1 <= 8'h00;
         d_s2 <= 8'h00;
      end else begin
         d_s1 <= bus.data;
         d_s2 <= d_s1;
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         rd_reg <= 1'b0;
         mode_reg <= odc_pkg::MODE_I80;
         dc_reg <= 1'b0;
         rdn_reg <= 1'b1;
         wrn_reg <= 1'b1;
         sck_reg <= 1'b1;
         csn_reg <= 1'b1;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_rdata <= 8'h00;
      end else begin
         o_done <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (i_start) begin
                  mode_reg <= i_mode;
                  dc_reg <= i_dc;
                  sh_reg <= i_wdata;
                  rd_reg <= i_is_read && i_mode != odc_pkg::MODE_SER;
                  o_busy <= 1'b1;
                  cnt_reg <= 4'h0;
                  bit_reg <= 4'h0;
                  // 6800 direction set ahead of enable
                  rdn_reg <= i_mode == odc_pkg::MODE_M68 ? 1'b0 : 1'b1;
                  wrn_reg <= i_mode == odc_pkg::MODE_M68 ? i_is_read : 1'b1;
                  csn_reg <= i_mode != odc_pkg::MODE_SER;
                  state_reg <= i_mode == odc_pkg::MODE_SER ? ST_SER : ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cnt_reg == 4'(odc_pkg::HOST_SETUP_CYC - 1)) begin
                  cnt_reg <= 4'h0;
                  state_reg <= ST_PULSE;
                  if (mode_reg == odc_pkg::MODE_M68)
                     rdn_reg <= 1'b1;
                  else if (rd_reg)
                     rdn_reg <= 1'b0;
                  else
                     wrn_reg <= 1'b0;
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            ST_PULSE: begin
               if (cnt_reg == 4'(odc_pkg::HOST_PULSE_CYC + 3)) begin
                  if (rd_reg)
                     o_rdata <= d_s2;
                  rdn_reg <= mode_reg == odc_pkg::MODE_M68 ? 1'b0 : 1'b1;
                  // 6800 direction holds past the enable fall
                  wrn_reg <= mode_reg == odc_pkg::MODE_M68 ? wrn_reg : 1'b1;
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            ST_SER: begin
               if (cnt_reg == 4'(odc_pkg::SER_HALF_CYC + 1)) begin
                  cnt_reg <= 4'h0;
                  // Select is raised a half period after the last rise
                  if (bit_reg == 4'h8) begin
                     csn_reg <= 1'b1;
                     o_busy <= 1'b0;
                     o_done <= 1'b1;
                     state_reg <= ST_IDLE;
                  end else begin
                     sck_reg <= !sck_reg;
                     if (sck_reg) begin
                        sh_reg <= {7'h00, sh_reg[7]} | (sh_reg << 1);
                     end else begin
                        bit_reg <= bit_reg + 4'h1;
                     end
                  end
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule

// ==== bench/odc_bus_assertions.sv ====
`timescale 1ns/100ps
module odc_bus_assertions (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic [1:0] mode,
   input wire logic dc_sel,
   input wire logic rd_n_e,
   input wire logic wr_n_rw,
   input wire logic [7:0] data_host,
   input wire logic data_dev_oe,
   input wire logic ser_clk,
   input wire logic ser_cs_n
);
   logic [3:0] rise_reg;
   logic clk_q_reg;
   logic i80, m68, ser;
   assign i80 = mode == odc_pkg::MODE_I80;
   assign m68 = mode == odc_pkg::MODE_M68;
   assign ser = mode == odc_pkg::MODE_SER;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rstn);
   // Serial clock rises since the frame opened
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         clk_q_reg <= 1'b0;
         rise_reg <= 4'h0;
      end else begin
         clk_q_reg <= ser_clk;
         if (ser_cs_n) begin
            rise_reg <= 4'h0;
         end else if (ser_clk && !clk_q_reg) begin
            rise_reg <= rise_reg + 4'h1;
         end
      end
   end
   sequence wr_open_s;
      i80 && $fell(wr_n_rw);
   endsequence
   sequence e_open_s;
      m68 && $rose(rd_n_e);
   endsequence
   a_i80_no_overlap: assert property (i80 |-> rd_n_e || wr_n_rw)
      else $error("read and write strobes low together");
   a_i80_wr_release: assert property (wr_open_s |-> ##[1:8] wr_n_rw)
      else $error("write strobe not released");
   a_i80_wr_hold: assert property (i80 && $past(i80) && !wr_n_rw && !$past(wr_n_rw)
      |-> $stable(data_host) && $stable(dc_sel)) else $error("write data moved");
   a_m68_e_release: assert property (e_open_s |-> ##[1:8] !rd_n_e)
      else $error("enable pulse not ended");
   a_m68_e_hold: assert property (m68 && $past(m68) && rd_n_e && $past(rd_n_e)
      |-> $stable(wr_n_rw) && $stable(data_host)) else $error("direction moved");
   a_write_no_drive: assert property (i80 && !wr_n_rw |-> !data_dev_oe)
      else $error("device drives during write");
   a_ser_idle_still: assert property (ser && $past(ser) && ser_cs_n && $past(ser_cs_n)
      |-> $stable(ser_clk)) else $error("serial clock moves outside frame");
   a_ser_eight_bits: assert property (ser && $rose(ser_cs_n) |-> rise_reg == 4'h8)
      else $error("frame without eight clock rises");
endmodule

// ==== bench/tb_oled_driver_command_decoder.sv ====
`timescale 1ns/100ps
module tb_oled_driver_command_decoder;
   typedef struct packed {
      logic [7:0] contrast;
      logic [7:0] col;
      logic [5:0] start;
      logic [1:0] volt;
      logic pump;
      logic remap;
      logic all_on;
      logic invert;
      logic pend;
   } odc_exp_s;
   logic i_clock, busy, done, osc_run, disp_tick, pump_on, seg_rev, all_on, invert;
   logic disp_on, hiz, ram_we;
   logic i_rstn = 1'b0;
   logic start = 1'b0;
   logic is_read = 1'b0;
   logic dc = 1'b0;
   logic osc_sel = 1'b1;
   logic tick_pin = 1'b0;
   logic clear_n = 1'b1;
   logic [1:0] mode = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] ram_rdata = 8'h00;
   logic [1:0] volt;
   logic [5:0] start_line;
   logic [7:0] rdata, ram_wdata, contrast, column;
   logic [7:0] codes [14] = '{8'h8a, 8'h8b, 8'ha1, 8'ha0, 8'ha5, 8'ha4, 8'ha7, 8'ha6,
      8'h30, 8'h31, 8'h32, 8'h33, 8'h40, 8'h7f};
   int errors, comparisons, cycles, we_count, exp_we, ticks;
   odc_exp_s exp_s;
   odc_bus_if bus_link ();
   odc_host i_odc_host (.i_clock(i_clock), .i_rstn(i_rstn), .bus(bus_link.host),
      .i_mode(mode), .i_start(start), .i_is_read(is_read), .i_dc(dc), .i_wdata(wdata),
      .o_busy(busy), .o_done(done), .o_rdata(rdata));
   odc_device i_odc_device (.i_clock(i_clock), .i_rstn(i_rstn), .bus(bus_link.device),
      .i_internal_osc_select(osc_sel), .i_outside_tick_pin(tick_pin),
      .i_chip_clear_input_n(clear_n), .i_ram_rdata(ram_rdata), .o_osc_run(osc_run),
      .o_disp_tick(disp_tick), .o_pump_on(pump_on), .o_pump_volt(volt),
      .o_contrast(contrast), .o_start_line(start_line), .o_seg_reverse(seg_rev),
      .o_all_on(all_on), .o_invert(invert), .o_display_on(disp_on), .o_driver_hiz(hiz),
      .o_column(column), .o_ram_we(ram_we), .o_ram_wdata(ram_wdata));
   odc_bus_assertions i_odc_bus_assertions (.i_clock(i_clock), .i_rstn(i_rstn),
      .mode(bus_link.mode), .dc_sel(bus_link.dc_sel), .rd_n_e(bus_link.rd_n_e),
      .wr_n_rw(bus_link.wr_n_rw), .data_host(bus_link.data_host),
      .data_dev_oe(bus_link.data_dev_oe), .ser_clk(bus_link.ser_clk),
      .ser_cs_n(bus_link.ser_cs_n));
   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   always @(negedge i_clock) begin
      if (disp_tick === 1'b1) ticks++;
      if (ram_we === 1'b1) we_count++;
   end
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         complete_run();
      end
   end
   task complete_run();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task check(input string what, input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, want, seen);
      end
   endtask
   function automatic odc_exp_s predict(odc_exp_s s, logic r, logic d, logic [7:0] b);
      odc_exp_s n;
      n = s;
      if (d && n.col < 8'h83) n.col = n.col + 8'h01;
      if (d || r) return n;
      n.pend = 1'b0;
      if (s.pend) n.contrast = b;
      if (s.pend) return n;
      if (b[7:4] == 4'h0) n.col[3:0] = b[3:0];
      if (b[7:4] == 4'h1) n.col[7:4] = b[3:0];
      if (b[7:2] == 6'h0c) n.volt = b[1:0];
      if (b[7:6] == 2'h1) n.start = b[5:0];
      if (b == 8'h81) n.pend = 1'b1;
      if (b[7:1] == 7'h45) n.pump = b[0];
      if (b[7:1] == 7'h50) n.remap = b[0];
      if (b[7:1] == 7'h52) n.all_on = b[0];
      if (b[7:1] == 7'h53) n.invert = b[0];
      return n;
   endfunction
   function automatic logic [7:0] rand_cmd(logic pend);
      logic [7:0] r;
      r = 8'($urandom);
      if (pend) return r;
      case ($urandom % 9)
         0: return {4'h0, r[3:0]};
         1: return {4'h1, r[3:0]};
         2: return {6'h0c, r[1:0]};
         3: return {2'h1, r[5:0]};
         4: return 8'h81;
         5: return {7'h45, r[0]};
         6: return {7'h50, r[0]};
         7: return {7'h52, r[0]};
         default: return {7'h53, r[0]};
      endcase
   endfunction
   task check_state();
      check("contrast", contrast, exp_s.contrast);
      check("column", column, exp_s.col);
      check("start line", {2'h0, start_line}, {2'h0, exp_s.start});
      check("pump volt", {6'h00, volt}, {6'h00, exp_s.volt});
      check("pump on", {7'h00, pump_on}, {7'h00, exp_s.pump});
      check("seg reverse", {7'h00, seg_rev}, {7'h00, exp_s.remap});
      check("all on", {7'h00, all_on}, {7'h00, exp_s.all_on});
      check("invert", {7'h00, invert}, {7'h00, exp_s.invert});
      check("display on", {7'h00, disp_on}, 8'h00);
      check("ram writes", we_count[7:0], exp_we[7:0]);
   endtask
   task xfer(input logic [1:0] m, input logic r, input logic d, input logic [7:0] b);
      int n;
      n = 0;
      @(posedge i_clock);
      mode <= m;
      is_read <= r;
      dc <= d;
      wdata <= b;
      start <= 1'b1;
      @(posedge i_clock);
      start <= 1'b0;
      while (done !== 1'b1 && n < 400) begin
         @(negedge i_clock);
         n++;
      end
      exp_s = predict(exp_s, r, d, b);
      if (d && !r) exp_we++;
      // Settings land a few cycles after the strobe ends
      repeat (8) @(negedge i_clock);
      check_state();
      if (r) check("read data", rdata, d ? ram_rdata : 8'h00);
      if (d && !r) check("ram data", ram_wdata, b);
   endtask
   task do_reset();
      @(posedge i_clock);
      i_rstn <= 1'b0;
      repeat (3) @(posedge i_clock);
      i_rstn <= 1'b1;
      exp_s = '{8'h80, 8'h00, 6'h00, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      @(negedge i_clock);
      check_state();
      check("driver hiz", {7'h00, hiz}, 8'h01);
   endtask
   initial begin
      void'($urandom(32'he680));
      do_reset();
      repeat (4) @(posedge i_clock);
      ticks = 0;
      repeat (20) @(posedge i_clock);
      check("internal ticks", ticks[7:0], 8'h0a);
      check("osc run", {7'h00, osc_run}, 8'h01);
      osc_sel <= 1'b0;
      repeat (6) @(posedge i_clock);
      ticks = 0;
      repeat (3) begin
         tick_pin <= 1'b1;
         repeat (4) @(posedge i_clock);
         tick_pin <= 1'b0;
         repeat (4) @(posedge i_clock);
      end
      check("outside ticks", ticks[7:0], 8'h03);
      check("osc run", {7'h00, osc_run}, 8'h00);
      for (int i = 0; i < 14; i++) xfer(2'(i % 3), 1'b0, 1'b0, codes[i]);
      for (int m = 0; m < 3; m++) begin
         repeat (8) xfer(2'(m), 1'b0, 1'b0, rand_cmd(exp_s.pend));
         if (exp_s.pend) xfer(2'(m), 1'b0, 1'b0, 8'h80);
         xfer(2'(m), 1'b0, 1'b0, 8'h81);
         xfer(2'(m), 1'b0, 1'b0, 8'ha5);
         // column 130, then past the end
         xfer(2'(m), 1'b0, 1'b0, 8'h02);
         xfer(2'(m), 1'b0, 1'b0, 8'h18);
         if (2'(m) != odc_pkg::MODE_SER) begin
            @(posedge i_clock);
            ram_rdata <= 8'($urandom);
            xfer(2'(m), 1'b1, 1'b1, 8'h00);
            xfer(2'(m), 1'b1, 1'b0, 8'h00);
         end
         xfer(2'(m), 1'b0, 1'b1, 8'ha5);
         repeat (2) xfer(2'(m), 1'b0, 1'b1, 8'($urandom));
      end
      clear_n <= 1'b0;
      repeat (4) @(negedge i_clock);
      check("driver hiz", {7'h00, hiz}, 8'h01);
      clear_n <= 1'b1;
      repeat (4) @(negedge i_clock);
      check_state();
      do_reset();
      complete_run();
   end
endmodule
